/* File: design/nps_probe_list.sv */
`timescale 1ns/1ps
module nps_probe_list import nps_pkg::*; #(
    parameter int DEPTH = LIST_DEPTH,
    parameter int AW = LIST_AW,
    parameter int W = PROBE_W
) (
    // clock
    input wire logic clk,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // read side
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
        $error("probe list depth does not fit its address");
    end

    logic [W-1:0] mem_r [DEPTH];

    always_ff @(posedge clk) begin
        if (ce && wr_en && int'(wr_addr) < DEPTH) begin
            mem_r[wr_addr] <= wr_data;
        end
        if (ce && rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule // nps_probe_list

/* File: design/nps_probe_sequencer.sv */
`timescale 1ns/1ps
module nps_probe_sequencer import nps_pkg::*; #(
    parameter int REEXCITE_CYCLES = REEXCITE_CYC,
    parameter int SUPERCYCLE_CYCLES = SUPERCYCLE_CYC,
    parameter int INJECTION_CYCLES = INJECTION_CYC,
    parameter int MAINS_CYCLES = MAINS_CYC,
    parameter int DIGI_CYCLES = DIGI_CYC,
    parameter int ZC_MAX_CYCLES = DIGI_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // sequence control
    input wire logic start,
    input wire nps_cfg_s cfg,
    input wire logic [ENV_W-1:0] env_threshold,
    // probe list loading
    input wire logic list_wr_en,
    input wire logic [LIST_AW-1:0] list_wr_addr,
    input wire logic [PROBE_W-1:0] list_wr_code,
    // accelerator timing pins
    input wire logic accel_event,
    input wire logic supercycle_event,
    // multiplexer and pulser
    output logic [PROBE_W-1:0] probe_sel,
    output logic spin_tip_trigger,
    input wire logic saturation_mask,
    input wire logic decay_signal,
    input wire logic [ENV_W-1:0] decay_envelope,
    input wire logic ref_clk_in,
    // digitizers
    output logic digitizer_trigger,
    // status and results
    output logic busy,
    output logic seq_done,
    output logic [LIST_AW-1:0] probe_index,
    output nps_count_s count,
    output logic count_valid
);
    localparam int CW = DLY_W;
    localparam int GW = $clog2(REEXCITE_CYCLES + 1);
    localparam int SW = $clog2(SUPERCYCLE_CYCLES + 1);

    if (INJECTION_CYCLES >= SUPERCYCLE_CYCLES || MAINS_CYCLES < 1
        || DIGI_CYCLES < 1 || REEXCITE_CYCLES < 1
        || MAINS_CYCLES > (1 << CW) || DIGI_CYCLES > (1 << CW)) begin : g_bad_params
        $error("sequencer timing parameters out of range");
    end

    // pin synchronisers, third stage for edge detection
    logic [2:0] acc_r, sc_r;
    logic acc_edge, sc_edge;
    assign acc_edge = nps_rise(acc_r[1], acc_r[2]);
    assign sc_edge = nps_rise(sc_r[1], sc_r[2]);

    // supercycle position
    logic [SW-1:0] sc_pos_r, sc_pos_nxt;
    logic in_inj, window_ok;

    // sequencer state
    nps_seq_e st_r, st_nxt;
    logic [LIST_AW-1:0] idx_r, idx_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [PROBE_W-1:0] sel_r, sel_nxt;
    logic fire_r, fire_nxt;
    logic trig_r, trig_nxt;
    logic done_r, done_nxt;
    logic [GW-1:0] guard_r [MAX_PROBES];
    logic [GW-1:0] guard_nxt [MAX_PROBES];

    // list memory and counter hookup
    logic rd_en;
    logic [PROBE_W-1:0] rd_code;
    logic zc_busy;
    logic last_step;
    logic sel_ok;
    logic probe_ready;
    logic [CW-1:0] shift_cyc;
    logic [CW-1:0] width_cyc;

    nps_probe_list #(
        .DEPTH(LIST_DEPTH),
        .AW(LIST_AW),
        .W(PROBE_W)
    ) u_list (
        .clk(clk),
        .ce(ce),
        .wr_en(list_wr_en),
        .wr_addr(list_wr_addr),
        .wr_data(list_wr_code),
        .rd_en(rd_en),
        .rd_addr(idx_r),
        .rd_data(rd_code)
    );

    nps_zc_counter #(
        .MAX_CYCLES(ZC_MAX_CYCLES)
    ) u_zc (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .arm(trig_r),
        .env_threshold(env_threshold),
        .saturation_mask(saturation_mask),
        .decay_signal(decay_signal),
        .decay_envelope(decay_envelope),
        .ref_clk_in(ref_clk_in),
        .count(count),
        .count_valid(count_valid),
        .busy(zc_busy)
    );

    assign rd_en = st_r == S_FETCH;
    assign in_inj = sc_pos_r < SW'(INJECTION_CYCLES);
    assign window_ok = !cfg.window_en || (in_inj == cfg.inj_inside);
    assign last_step = 32'(idx_r) + 1 >= 32'(cfg.list_len) || 32'(idx_r) + 1 >= LIST_DEPTH;
    assign sel_ok = 32'(sel_r) < MAX_PROBES;
    assign probe_ready = sel_ok && guard_r[sel_r[PROBE_W-1:0] % PROBE_W'(MAX_PROBES)] == '0;
    assign shift_cyc = (32'(cfg.mains_shift) >= MAINS_CYCLES)
        ? CW'(MAINS_CYCLES - 1) : CW'(cfg.mains_shift);
    assign width_cyc = (cfg.pulse_width == '0) ? CW'(1) : CW'(cfg.pulse_width);

    assign probe_sel = sel_r;
    assign spin_tip_trigger = fire_r;
    assign digitizer_trigger = trig_r;
    assign seq_done = done_r;
    assign busy = st_r != S_IDLE;
    assign probe_index = idx_r;

    // supercycle position: restarts on each supercycle mark, saturates
    always_comb begin
        sc_pos_nxt = sc_pos_r;
        if (sc_edge) begin
            sc_pos_nxt = '0;
        end else if (sc_pos_r < SW'(SUPERCYCLE_CYCLES)) begin
            sc_pos_nxt = sc_pos_r + 1'b1;
        end
    end

    // per-probe re-excitation guard
    always_comb begin
        for (int i = 0; i < MAX_PROBES; i++) begin
            guard_nxt[i] = (guard_r[i] != '0) ? guard_r[i] - 1'b1 : guard_r[i];
        end
        if (st_r == S_GATE && window_ok && probe_ready) begin
            guard_nxt[sel_r % PROBE_W'(MAX_PROBES)] = GW'(REEXCITE_CYCLES);
        end
    end

    // step sequencer
    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
        sel_nxt = sel_r;
        fire_nxt = 1'b0;
        trig_nxt = 1'b0;
        done_nxt = done_r;
        case (st_r)
            S_IDLE: begin
                if (start) begin
                    done_nxt = 1'b0;
                    idx_nxt = '0;
                    if (cfg.list_len == '0) begin
                        done_nxt = 1'b1;
                    end else begin
                        st_nxt = S_FETCH;
                    end
                end
            end
            S_FETCH: st_nxt = S_LOAD;
            S_LOAD: begin
                sel_nxt = rd_code;
                st_nxt = S_SYNC;
            end
            S_SYNC: begin
                if (!cfg.sync_en || acc_edge) begin
                    st_nxt = S_DELAY;
                    cnt_nxt = cfg.start_delay;
                end
            end
            S_DELAY: begin
                if (cnt_r == '0) begin
                    st_nxt = S_SHIFT;
                    cnt_nxt = shift_cyc;
                end
            end
            S_SHIFT: begin
                if (cnt_r == '0) begin
                    st_nxt = S_GATE;
                end
            end
            S_GATE: begin
                if (!sel_ok) begin
                    st_nxt = S_ACQ;
                    cnt_nxt = '0;
                end else if (window_ok && probe_ready) begin
                    st_nxt = S_FIRE;
                    fire_nxt = 1'b1;
                    cnt_nxt = width_cyc - 1'b1;
                end
            end
            S_FIRE: begin
                if (cnt_r == '0) begin
                    st_nxt = S_ACQ;
                    trig_nxt = 1'b1;
                    cnt_nxt = CW'(DIGI_CYCLES - 1);
                end else begin
                    fire_nxt = 1'b1;
                end
            end
            S_ACQ: begin
                if (cnt_r == '0 && !zc_busy && !trig_r) begin
                    if (last_step) begin
                        st_nxt = S_IDLE;
                        done_nxt = 1'b1;
                    end else begin
                        idx_nxt = idx_r + 1'b1;
                        st_nxt = S_FETCH;
                    end
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            acc_r <= '0;
            sc_r <= '0;
            sc_pos_r <= SW'(SUPERCYCLE_CYCLES);
            st_r <= S_IDLE;
            idx_r <= '0;
            cnt_r <= '0;
            sel_r <= '0;
            fire_r <= 1'b0;
            trig_r <= 1'b0;
            done_r <= 1'b0;
            for (int i = 0; i < MAX_PROBES; i++) begin
                guard_r[i] <= '0;
            end
        end else if (ce) begin
            acc_r <= {acc_r[1:0], accel_event};
            sc_r <= {sc_r[1:0], supercycle_event};
            sc_pos_r <= sc_pos_nxt;
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            sel_r <= sel_nxt;
            fire_r <= fire_nxt;
            trig_r <= trig_nxt;
            done_r <= done_nxt;
            for (int i = 0; i < MAX_PROBES; i++) begin
                guard_r[i] <= guard_nxt[i];
            end
        end
    end
endmodule // nps_probe_sequencer

/* File: design/nps_zc_counter.sv */
`timescale 1ns/1ps
module nps_zc_counter import nps_pkg::*; #(
    parameter int MAX_CYCLES = DIGI_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // control
    input wire logic arm,
    input wire logic [ENV_W-1:0] env_threshold,
    // pins
    input wire logic saturation_mask,
    input wire logic decay_signal,
    input wire logic [ENV_W-1:0] decay_envelope,
    input wire logic ref_clk_in,
    // result
    output nps_count_s count,
    output logic count_valid,
    output logic busy
);
    localparam int TW = $clog2(MAX_CYCLES + 1);
    if (MAX_CYCLES < 1) begin : g_bad_max
        $error("zero-crossing timeout must be at least one cycle");
    end

    logic [2:0] sig_r, ref_r;
    logic [1:0] mask_r;
    logic [ENV_W-1:0] env1_r, env2_r;
    nps_zc_e st_r, st_nxt;
    logic [TW-1:0] tmr_r, tmr_nxt;
    logic [CNT_W-1:0] k_r, k_nxt, n_r, n_nxt;
    nps_count_s count_nxt;
    logic valid_nxt;
    logic pos_x, tick, env_low, tmo, stop;

    assign pos_x = nps_rise(sig_r[2], sig_r[1]) == 1'b0 && nps_rise(sig_r[1], sig_r[2]);
    assign tick = nps_rise(ref_r[1], ref_r[2]);
    assign env_low = env2_r < env_threshold;
    assign tmo = tmr_r == '0;
    assign stop = env_low || tmo;
    assign busy = st_r != Z_IDLE;

    always_comb begin
        st_nxt = st_r;
        tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
        k_nxt = k_r;
        n_nxt = n_r + CNT_W'(tick);
        count_nxt = count;
        valid_nxt = 1'b0;
        case (st_r)
            Z_IDLE: begin
                if (arm) begin
                    st_nxt = Z_MASK;
                    tmr_nxt = TW'(MAX_CYCLES - 1);
                end
            end
            Z_MASK: begin
                if (tmo) begin
                    st_nxt = Z_IDLE;
                    count_nxt = '{crossings: '0, ticks: '0, timed_out: 1'b1};
                    valid_nxt = 1'b1;
                end else if (!mask_r[1]) begin
                    st_nxt = Z_FIRST;
                end
            end
            Z_FIRST: begin
                if (stop) begin
                    st_nxt = Z_IDLE;
                    count_nxt = '{crossings: '0, ticks: '0, timed_out: tmo};
                    valid_nxt = 1'b1;
                end else if (pos_x) begin
                    st_nxt = Z_COUNT;
                    k_nxt = '0;
                    n_nxt = '0;
                end
            end
            Z_COUNT: begin
                if (pos_x) begin
                    k_nxt = k_r + 1'b1;
                    count_nxt.crossings = k_r + 1'b1;
                    count_nxt.ticks = n_r + CNT_W'(tick);
                end
                if (stop) begin
                    st_nxt = Z_IDLE;
                    count_nxt.timed_out = tmo;
                    valid_nxt = 1'b1;
                end
            end
            default: st_nxt = Z_IDLE;
        endcase
        if (st_r == Z_IDLE && arm) begin
            count_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sig_r <= '0;
            ref_r <= '0;
            mask_r <= '0;
            env1_r <= '0;
            env2_r <= '0;
            st_r <= Z_IDLE;
            tmr_r <= '0;
            k_r <= '0;
            n_r <= '0;
            count <= '0;
            count_valid <= 1'b0;
        end else if (ce) begin
            sig_r <= {sig_r[1:0], decay_signal};
            ref_r <= {ref_r[1:0], ref_clk_in};
            mask_r <= {mask_r[0], saturation_mask};
            env1_r <= decay_envelope;
            env2_r <= env1_r;
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            k_r <= k_nxt;
            n_r <= n_nxt;
            count <= count_nxt;
            count_valid <= valid_nxt;
        end
    end
endmodule // nps_zc_counter

/* File: inc/nps_pkg.sv */
package nps_pkg;
    // clock and probe addressing
    localparam int CLK_HZ = 10_000_000;
    localparam int PROBE_W = 5;
    localparam int MAX_PROBES = 20;
    localparam int LIST_DEPTH = 32;
    localparam int LIST_AW = 5;
    localparam int LIST_LEN_W = 6;
    // field widths
    localparam int PW_W = 16;
    localparam int DLY_W = 24;
    localparam int SHIFT_W = 18;
    localparam int ENV_W = 12;
    localparam int CNT_W = 32;
    // times as printed, and their cycle counts
    localparam int REEXCITE_MS = 400;
    localparam int REEXCITE_CYC = REEXCITE_MS * (CLK_HZ / 1000);
    localparam int MAINS_PERIOD_US = 17000;
    localparam int MAINS_CYC = MAINS_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int DIGI_WINDOW_US = 5000;
    localparam int DIGI_CYC = DIGI_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int SUPERCYCLE_MS = 1330;
    localparam int SUPERCYCLE_CYC = SUPERCYCLE_MS * (CLK_HZ / 1000);
    localparam int INJECTION_MS = 500;
    localparam int INJECTION_CYC = INJECTION_MS * (CLK_HZ / 1000);
    localparam int REF_HZ = 20_000_000;

    typedef struct packed {
        logic [LIST_LEN_W-1:0] list_len;
        logic [PW_W-1:0] pulse_width;
        logic [DLY_W-1:0] start_delay;
        logic [SHIFT_W-1:0] mains_shift;
        logic sync_en;
        logic window_en;
        logic inj_inside;
    } nps_cfg_s;

    typedef struct packed {
        logic [CNT_W-1:0] crossings;
        logic [CNT_W-1:0] ticks;
        logic timed_out;
    } nps_count_s;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_LOAD, S_SYNC, S_DELAY, S_SHIFT, S_GATE, S_FIRE, S_ACQ
    } nps_seq_e;

    typedef enum logic [1:0] {
        Z_IDLE, Z_MASK, Z_FIRST, Z_COUNT
    } nps_zc_e;

    function automatic logic nps_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction
endpackage

/* File: sim/nps_far_model.sv */
`timescale 1ns/1ps
module nps_far_model import nps_pkg::*; #(
    parameter int MASK_CYC = 8,
    parameter int HALF_PER = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // from the sequencer
    input wire logic [PROBE_W-1:0] probe_sel,
    input wire logic spin_tip_trigger,
    // pulser/mixer outputs
    output logic saturation_mask,
    output logic decay_signal,
    output logic [ENV_W-1:0] decay_envelope,
    output logic ref_clk_in
);
    int mask_n = 0;
    int ph_n = 0;
    logic [1:0] rc_n = 2'b00;

    initial begin
        saturation_mask = 1'b0;
        decay_signal = 1'b0;
        decay_envelope = '0;
        ref_clk_in = 1'b0;
    end
    always @(posedge clk) begin
        // reference runs at a quarter of clk
        rc_n <= rc_n + 2'b01;
        ref_clk_in <= rc_n[1];
        saturation_mask <= spin_tip_trigger || mask_n > 0;
        mask_n <= spin_tip_trigger ? MASK_CYC : (mask_n > 0 ? mask_n - 1 : 0);
        if (spin_tip_trigger && int'(probe_sel) < MAX_PROBES) begin
            decay_envelope <= '1;
            decay_signal <= 1'b0;
            ph_n <= 0;
        end else if (decay_envelope != '0) begin
            decay_envelope <= (decay_envelope > 12'h0040) ? decay_envelope - 12'h0040 : '0;
            ph_n <= (ph_n == HALF_PER - 1) ? 0 : ph_n + 1;
            if (ph_n == HALF_PER - 1) begin
                decay_signal <= ~decay_signal;
            end
        end
    end
endmodule // nps_far_model

/* File: sim/nps_seq_checker.sv */
`timescale 1ns/1ps
module nps_seq_checker import nps_pkg::*; #(
    parameter int REEXCITE_CYCLES = REEXCITE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // control
    input wire logic start,
    input wire nps_cfg_s cfg,
    // outputs watched
    input wire logic [PROBE_W-1:0] probe_sel,
    input wire logic spin_tip_trigger,
    input wire logic digitizer_trigger,
    input wire logic busy,
    input wire logic seq_done,
    input wire nps_count_s count,
    input wire logic count_valid
);
    logic [31:0] cyc_r, cyc_nxt, wid_r, wid_nxt;
    logic [31:0] last_r [32];
    logic [31:0] seen_r;
    logic spin_d_r, rise;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    always_comb begin
        cyc_nxt = cyc_r + 32'h0000_0001;
        wid_nxt = spin_tip_trigger ? wid_r + 32'h0000_0001 : 32'h0000_0000;
        rise = spin_tip_trigger & ~spin_d_r;
    end
    // per-code time of last pulse start
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cyc_r <= '0;
            wid_r <= '0;
            seen_r <= '0;
            spin_d_r <= 1'b0;
        end else begin
            cyc_r <= cyc_nxt;
            wid_r <= wid_nxt;
            spin_d_r <= spin_tip_trigger;
            if (rise) begin
                last_r[probe_sel] <= cyc_r;
                seen_r[probe_sel] <= 1'b1;
            end
        end
    end

    AST_RESET: assert property (disable iff (1'b0) ce && !rst_b |=>
        probe_sel == '0 && !spin_tip_trigger && !busy && !seq_done && !count_valid)
        else $error("outputs not cleared by reset");
    AST_WIDTH: assert property ($fell(spin_tip_trigger) |->
        wid_r == ((cfg.pulse_width == '0) ? 32'h0000_0001 : 32'(cfg.pulse_width)))
        else $error("spin tip width differs from setting");
    AST_DIGI_AT_END: assert property ($fell(spin_tip_trigger) |-> digitizer_trigger)
        else $error("no digitizer trigger at end of pulse");
    AST_DIGI_PULSE: assert property (digitizer_trigger |=> !digitizer_trigger)
        else $error("digitizer trigger longer than one cycle");
    AST_SEL_STABLE: assert property (spin_tip_trigger |-> $stable(probe_sel))
        else $error("probe select moved during pulse");
    AST_SEL_RANGE: assert property ($rose(spin_tip_trigger) |-> int'(probe_sel) < MAX_PROBES)
        else $error("pulse fired for an unrouted code");
    AST_REEXCITE: assert property (rise && seen_r[probe_sel] |->
        cyc_r - last_r[probe_sel] >= 32'(REEXCITE_CYCLES))
        else $error("probe excited again too soon");
    AST_START_BUSY: assert property (ce && start && !busy && cfg.list_len != '0 |=> busy [*2])
        else $error("accepted start did not raise busy");
    AST_START_EMPTY: assert property (ce && start && !busy && cfg.list_len == '0 |=>
        seq_done && !busy)
        else $error("empty list did not finish at once");
    AST_CE_FREEZE: assert property (!ce |=> $stable(probe_sel) && $stable(busy)
        && $stable(seq_done) && $stable(spin_tip_trigger) && $stable(digitizer_trigger))
        else $error("outputs moved while clock enable low");
    AST_DONE_HOLD: assert property (seq_done && !start |=> seq_done)
        else $error("done flag dropped without start");
    AST_DONE_IDLE: assert property (seq_done |-> !busy && !spin_tip_trigger)
        else $error("done flag while sequence active");
    AST_VALID_PULSE: assert property (count_valid |=> !count_valid)
        else $error("count valid longer than one cycle");
    AST_TICKS: assert property (count_valid && count.crossings != '0 |-> count.ticks != '0)
        else $error("crossings counted without ticks");

    cover property ($rose(seq_done));
    cover property (digitizer_trigger);
    cover property (count_valid && count.crossings != '0);
endmodule // nps_seq_checker

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top import nps_pkg::*;;
    localparam int REEXCITE_CYCLES = 50;
    localparam int SC_CYC = 200;
    localparam int DIGI_CYCLES = 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic accel_event = 1'b0;
    logic supercycle_event = 1'b0;
    logic list_wr_en = 1'b0;
    logic [LIST_AW-1:0] list_wr_addr = '0;
    logic [PROBE_W-1:0] list_wr_code = '0;
    logic [ENV_W-1:0] env_threshold = 12'h0400;
    nps_cfg_s cfg = '0;
    logic [PROBE_W-1:0] probe_sel;
    logic spin_tip_trigger, saturation_mask, decay_signal, ref_clk_in;
    logic digitizer_trigger, busy, seq_done, count_valid, spin_d;
    logic [ENV_W-1:0] decay_envelope;
    logic [LIST_AW-1:0] probe_index;
    nps_count_s count;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int pos = 1000;
    int rise_n = 0;
    int digi_n = 0;
    int rise_cyc = 0;
    int digi_cyc = 0;
    int prev_rise = 0;
    logic [PROBE_W-1:0] sel_q[$];
    logic [PROBE_W-1:0] codes[6];

    always #50 clk = ~clk;

    nps_probe_sequencer #(.REEXCITE_CYCLES(REEXCITE_CYCLES), .SUPERCYCLE_CYCLES(SC_CYC),
        .INJECTION_CYCLES(75), .MAINS_CYCLES(20), .DIGI_CYCLES(DIGI_CYCLES), .ZC_MAX_CYCLES(100))
    u_nps_probe_sequencer (.clk(clk), .rst_b(rst_b), .ce(ce), .start(start), .cfg(cfg),
        .env_threshold(env_threshold), .list_wr_en(list_wr_en), .list_wr_addr(list_wr_addr),
        .list_wr_code(list_wr_code), .accel_event(accel_event),
        .supercycle_event(supercycle_event), .probe_sel(probe_sel),
        .spin_tip_trigger(spin_tip_trigger), .saturation_mask(saturation_mask),
        .decay_signal(decay_signal), .decay_envelope(decay_envelope), .ref_clk_in(ref_clk_in),
        .digitizer_trigger(digitizer_trigger), .busy(busy), .seq_done(seq_done),
        .probe_index(probe_index), .count(count), .count_valid(count_valid));
    nps_far_model u_nps_far_model (.clk(clk), .rst_b(rst_b), .probe_sel(probe_sel),
        .spin_tip_trigger(spin_tip_trigger), .saturation_mask(saturation_mask),
        .decay_signal(decay_signal), .decay_envelope(decay_envelope), .ref_clk_in(ref_clk_in));

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // decay period 6 cycles, reference period 4 cycles
    function automatic logic ratio_ok(input logic [31:0] k, input logic [31:0] t);
        longint d;
        d = 4 * longint'(t) - 6 * longint'(k);
        return d >= -4 && d <= 4;
    endfunction
    task automatic load(input int len);
        for (int i = 0; i < len; i++) begin
            @(negedge clk);
            list_wr_en = 1'b1;
            list_wr_addr = LIST_AW'(i);
            list_wr_code = codes[i];
        end
        @(negedge clk);
        list_wr_en = 1'b0;
    endtask
    task automatic run_seq(input int len, output int lat);
        int n;
        cfg.list_len = LIST_LEN_W'(len);
        load(len);
        sel_q = {};
        start = 1'b1;
        lat = 0;
        for (n = 0; n < 4000; n++) begin
            @(negedge clk);
            start = 1'b0;
            if (spin_tip_trigger === 1'b1 && lat == 0) lat = n;
            if (seq_done === 1'b1 && busy === 1'b0) break;
        end
        if (n == 4000) begin
            num_errors++;
            stop_test();
        end
        repeat (60) @(negedge clk);
    endtask

    always @(negedge clk) supercycle_event <= (cyc % SC_CYC) == 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pos <= supercycle_event ? 0 : pos + 1;
        spin_d <= spin_tip_trigger;
        if (rst_b && spin_tip_trigger && !spin_d) begin
            sel_q.push_back(probe_sel);
            rise_n <= rise_n + 1;
            prev_rise <= rise_cyc;
            rise_cyc <= cyc;
            if (cfg.window_en) begin
                chk(cfg.inj_inside ? (pos >= 2 && pos < 82) : (pos >= 75 || pos < 8), 1);
            end
        end
        // digitizer stand-in: counts triggers and checks they are at least DIGI_CYCLES apart
        if (rst_b && digitizer_trigger) begin
            if (digi_n > 0) chk(cyc - digi_cyc >= DIGI_CYCLES, 1);
            digi_n <= digi_n + 1;
            digi_cyc <= cyc;
        end
        if (rst_b && count_valid) begin
            chk(ratio_ok(count.crossings, count.ticks), 1);
            chk(count.timed_out, 0);
        end
    end

    initial begin
        int lat0, lat, d, s, len, j, r0;
        logic [PROBE_W-1:0] exp_q[$];
        void'($urandom(32'h5250));
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        chk({probe_sel, seq_done, busy, count_valid, spin_tip_trigger}, 0);
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 0 : $urandom_range(0, 30);
            s = (k == 0) ? 0 : $urandom_range(0, 25);
            len = (k == 0) ? 2 : $urandom_range(2, 6);
            j = $urandom_range(1, len - 1);
            cfg.start_delay = DLY_W'(d);
            cfg.mains_shift = SHIFT_W'(s);
            cfg.pulse_width = PW_W'($urandom_range(0, 8));
            env_threshold = ENV_W'($urandom_range(400, 2000));
            exp_q = {};
            for (int i = 0; i < len; i++) begin
                codes[i] = (i == j) ? PROBE_W'($urandom_range(20, 31)) : PROBE_W'($urandom_range(0, 19));
                if (i != j) exp_q.push_back(codes[i]);
            end
            r0 = digi_n;
            run_seq(len, lat);
            if (k == 0) lat0 = lat;
            chk(lat, lat0 + d + ((s > 19) ? 19 : s));
            chk(sel_q.size(), exp_q.size());
            foreach (exp_q[i]) chk(sel_q[i], exp_q[i]);
            chk(digi_n - r0, exp_q.size());
            chk({seq_done, busy}, 2'b10);
            chk(probe_index, LIST_AW'(len - 1));
        end
        cfg.start_delay = '0;
        cfg.mains_shift = '0;
        r0 = rise_n;
        run_seq(0, lat);
        chk({rise_n - r0, 31'(seq_done)}, 1);
        codes[0] = 5'h07;
        codes[1] = 5'h07;
        run_seq(2, lat);
        chk(rise_cyc - prev_rise >= REEXCITE_CYCLES, 1);
        cfg.sync_en = 1'b1;
        codes[0] = 5'h03;
        r0 = rise_n;
        fork
            run_seq(1, lat);
            begin
                repeat (15) @(negedge clk);
                ce = 1'b0;
                repeat (10) @(negedge clk);
                chk(busy, 1);
                ce = 1'b1;
                repeat (15) @(negedge clk);
                chk(rise_n, r0);
                accel_event = 1'b1;
                repeat (4) @(negedge clk);
                accel_event = 1'b0;
            end
        join
        chk(rise_n, r0 + 1);
        cfg.sync_en = 1'b0;
        cfg.window_en = 1'b1;
        for (int w = 0; w < 2; w++) begin
            cfg.inj_inside = w[0];
            codes[0] = PROBE_W'($urandom_range(0, 19));
            codes[1] = PROBE_W'($urandom_range(0, 19));
            run_seq(2, lat);
        end
        stop_test();
    end
endmodule // tb_top

bind nps_probe_sequencer nps_seq_checker #(.REEXCITE_CYCLES(REEXCITE_CYCLES)) u_nps_seq_checker (
    .clk(clk), .rst_b(rst_b), .ce(ce), .start(start), .cfg(cfg), .probe_sel(probe_sel),
    .spin_tip_trigger(spin_tip_trigger), .digitizer_trigger(digitizer_trigger), .busy(busy),
    .seq_done(seq_done), .count(count), .count_valid(count_valid));
